// ### rtl/apc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - any reset clears control register
// - clear bit write zeroes index
// - clear bit self-clears in hardware
// - clear beats any stepping
// - clear bit always reads zero
// - direction zero increments after operations
// - direction one decrements after operations
// - wrap code zero: no stepping
// - bits five to three read zero
// - code 001: bit 0 modulo 2
// - code 010: bits 1:0 modulo 4
// - code 011: bits 2:0 modulo 8
// - code 100: full index modulo 16
// - reserved codes act as modulo 16
// - register access never restricted
// - four-bit index selects sixteen accumulators
// - stepping overrides direct index write
module apc_top
    import apc_pkg::*;
(
    input  wire logic                            CLK_SYS_IN,
    input  wire logic                            NRST_IN,
    input  wire logic                            REG_WR_IN,
    input  wire logic [apc_pkg::APC_ADDR_W-1:0]  REG_ADDR_IN,
    input  wire logic [apc_pkg::APC_DATA_W-1:0]  REG_WDATA_IN,
    input  wire logic                            ALU_DONE_IN,
    output logic      [apc_pkg::APC_DATA_W-1:0]  REG_RDATA_OUT,
    output logic      [apc_pkg::APC_IDX_W-1:0]   ACC_INDEX_OUT
);
    import apc_pkg::*;

    logic                  dir_r;
    logic                  dir_nxt;
    logic [APC_WRAP_W-1:0] wrap_r;
    logic [APC_WRAP_W-1:0] wrap_nxt;
    logic [APC_IDX_W-1:0]  idx_r;
    logic [APC_IDX_W-1:0]  idx_nxt;
    logic [APC_DATA_W-1:0] rdata_r;
    logic [APC_DATA_W-1:0] rdata_nxt;
    logic [APC_IDX_W-1:0]  stepped;
    logic                  step_on;
    logic                  wr_ctrl;
    logic                  wr_idx;
    logic                  zero_req;
    logic [APC_DATA_W-1:0] ctrl_view;
    apc_act_type           act;

    apc_step u_step (
        .idx_in     (idx_r),
        .wrap_in    (wrap_r),
        .dir_in     (dir_r),
        .idx_out    (stepped),
        .active_out (step_on)
    );

    // clear bit is never stored, so the view holds it at zero
    assign ctrl_view = {1'b0, dir_r, 3'h0, wrap_r};

    apc_regs u_regs (
        .addr_in  (REG_ADDR_IN),
        .ctrl_in  (ctrl_view),
        .idx_in   (idx_nxt),
        .data_out (rdata_nxt)
    );

    always_comb
    begin
        wr_ctrl  = REG_WR_IN && (REG_ADDR_IN == APC_CTRL_IDX);
        wr_idx   = REG_WR_IN && (REG_ADDR_IN == APC_INDEX_IDX);
        zero_req = wr_ctrl && REG_WDATA_IN[APC_ZERO_BIT];
        dir_nxt  = dir_r;
        wrap_nxt = wrap_r;
        if (wr_ctrl)
        begin
            dir_nxt  = REG_WDATA_IN[APC_DIR_BIT];
            wrap_nxt = REG_WDATA_IN[APC_WRAP_LSB +: APC_WRAP_W];
        end
        if (zero_req)
            act = APC_ACT_ZERO;
        else if (ALU_DONE_IN && step_on)
            act = APC_ACT_STEP;
        else if (wr_idx)
            act = APC_ACT_LOAD;
        else
            act = APC_ACT_HOLD;
        case (act)
            APC_ACT_ZERO: idx_nxt = APC_INDEX_RST;
            APC_ACT_STEP: idx_nxt = stepped;
            APC_ACT_LOAD: idx_nxt = REG_WDATA_IN[APC_IDX_W-1:0];
            default:      idx_nxt = idx_r;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!NRST_IN)
        begin
            dir_r   <= APC_CTRL_RST[APC_DIR_BIT];
            wrap_r  <= APC_CTRL_RST[APC_WRAP_LSB +: APC_WRAP_W];
            idx_r   <= APC_INDEX_RST;
            rdata_r <= APC_CTRL_RST;
        end
        else
        begin
            dir_r   <= dir_nxt;
            wrap_r  <= wrap_nxt;
            idx_r   <= idx_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_RDATA_OUT = rdata_r;
    assign ACC_INDEX_OUT = idx_r;

    a_reset_clears: assert property (@(posedge CLK_SYS_IN)
        !NRST_IN |=> (wrap_r == APC_WRAP_OFF) && !dir_r && idx_r == '0)
        else $error("reset did not clear control");

    a_reset_rdata: assert property (@(posedge CLK_SYS_IN)
        !NRST_IN |=> REG_RDATA_OUT == APC_CTRL_RST
        && ACC_INDEX_OUT == APC_INDEX_RST)
        else $error("reset did not clear outputs");

    a_reset_fields: assert property (@(posedge CLK_SYS_IN)
        !NRST_IN ##1 NRST_IN && REG_ADDR_IN == APC_CTRL_IDX
        |=> REG_RDATA_OUT == APC_CTRL_RST)
        else $error("control not zero after reset");

    a_clear_zeroes: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        REG_WR_IN && REG_ADDR_IN == APC_CTRL_IDX
        && REG_WDATA_IN[APC_ZERO_BIT] |=> ACC_INDEX_OUT == '0)
        else $error("clear did not zero index");

    a_clear_dir_kept: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        zero_req |=> dir_r == $past(REG_WDATA_IN[APC_DIR_BIT]))
        else $error("clear write lost direction");

    a_clear_wins: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        zero_req && ALU_DONE_IN && step_on |=> idx_r == '0)
        else $error("step beat clear");

    a_ctrl_write: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        wr_ctrl
        |=> wrap_r == $past(REG_WDATA_IN[APC_WRAP_LSB +: APC_WRAP_W])
        && dir_r == $past(REG_WDATA_IN[APC_DIR_BIT]))
        else $error("control write not stored");

    a_clear_reads: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        REG_ADDR_IN == APC_CTRL_IDX |=> !REG_RDATA_OUT[APC_ZERO_BIT])
        else $error("clear bit read nonzero");

    a_ctrl_read: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        !REG_WR_IN && REG_ADDR_IN == APC_CTRL_IDX
        |=> REG_RDATA_OUT[APC_WRAP_LSB +: APC_WRAP_W] == wrap_r
        && REG_RDATA_OUT[APC_DIR_BIT] == dir_r)
        else $error("control read wrong");

    a_self_clear: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        zero_req ##1 REG_ADDR_IN == APC_CTRL_IDX
        |=> !REG_RDATA_OUT[APC_ZERO_BIT])
        else $error("clear bit stuck");

    a_index_read: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        REG_ADDR_IN == APC_INDEX_IDX
        |=> REG_RDATA_OUT == {{(APC_DATA_W-APC_IDX_W){1'b0}}, ACC_INDEX_OUT})
        else $error("index read wrong");

    a_rsvd_zero: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        REG_ADDR_IN == APC_CTRL_IDX |=> REG_RDATA_OUT[5:3] == 3'h0)
        else $error("reserved bits nonzero");

    a_unmapped_read: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        REG_ADDR_IN != APC_CTRL_IDX && REG_ADDR_IN != APC_INDEX_IDX
        |=> REG_RDATA_OUT == '0)
        else $error("unmapped read nonzero");

    a_step_inc: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        ALU_DONE_IN && !REG_WR_IN && wrap_r >= 3'h4 && !dir_r
        |=> idx_r == $past(idx_r) + 4'h1)
        else $error("increment wrong");

    a_idx_load: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        wr_idx && !(ALU_DONE_IN && step_on)
        |=> idx_r == $past(REG_WDATA_IN[APC_IDX_W-1:0]))
        else $error("index write lost");

    a_step_dec: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        ALU_DONE_IN && !REG_WR_IN && wrap_r >= 3'h4 && dir_r
        |=> idx_r == $past(idx_r) - 4'h1)
        else $error("decrement wrong");

    a_idle_hold: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        !REG_WR_IN && !ALU_DONE_IN |=> $stable(idx_r))
        else $error("index moved while idle");

    a_no_step: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        !REG_WR_IN && wrap_r == APC_WRAP_OFF |=> $stable(idx_r))
        else $error("index moved with stepping off");

    a_dir_ignored: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        ALU_DONE_IN && !REG_WR_IN && wrap_r == APC_WRAP_OFF && dir_r
        |=> $stable(idx_r))
        else $error("direction used with stepping off");

    a_mod2_upper: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        !REG_WR_IN && wrap_r == APC_WRAP_2
        |=> idx_r[3:1] == $past(idx_r[3:1]))
        else $error("modulo 2 touched upper bits");

    a_mod2_low: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        ALU_DONE_IN && !REG_WR_IN && wrap_r == APC_WRAP_2
        |=> idx_r[0] != $past(idx_r[0]))
        else $error("modulo 2 did not toggle");

    a_mod4_upper: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        !REG_WR_IN && wrap_r == APC_WRAP_4
        |=> idx_r[3:2] == $past(idx_r[3:2]))
        else $error("modulo 4 touched upper bits");

    a_mod4_low: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        ALU_DONE_IN && !REG_WR_IN && wrap_r == APC_WRAP_4
        |=> idx_r[1:0] == ($past(dir_r) ? $past(idx_r[1:0]) - 2'h1
                                        : $past(idx_r[1:0]) + 2'h1))
        else $error("modulo 4 step wrong");

    a_mod8_upper: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        !REG_WR_IN && wrap_r == APC_WRAP_8 |=> idx_r[3] == $past(idx_r[3]))
        else $error("modulo 8 touched top bit");

    a_mod8_low: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        ALU_DONE_IN && !REG_WR_IN && wrap_r == APC_WRAP_8
        |=> idx_r[2:0] == ($past(dir_r) ? $past(idx_r[2:0]) - 3'h1
                                        : $past(idx_r[2:0]) + 3'h1))
        else $error("modulo 8 step wrong");

    a_step_over_load: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        wr_idx && ALU_DONE_IN && step_on |=> idx_r == $past(stepped))
        else $error("direct write beat stepping");

    a_rsvd_full: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        ALU_DONE_IN && !REG_WR_IN && wrap_r > APC_WRAP_8 && !dir_r
        |=> idx_r == $past(idx_r) + APC_ONE)
        else $error("reserved code not modulo 16");

    a_rsvd_dec: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        ALU_DONE_IN && !REG_WR_IN && wrap_r > APC_WRAP_8 && dir_r
        |=> idx_r == $past(idx_r) - APC_ONE)
        else $error("reserved code not modulo 16 down");

    a_clear_stores: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        zero_req |=> wrap_r == $past(REG_WDATA_IN[2:0]))
        else $error("clear write lost fields");

    a_ctrl_hold: assert property (@(posedge CLK_SYS_IN)
        disable iff (!NRST_IN)
        !wr_ctrl |=> $stable(wrap_r) && $stable(dir_r))
        else $error("control changed without write");

    c_clear: cover property (@(posedge CLK_SYS_IN) zero_req);
    c_wrap16: cover property (@(posedge CLK_SYS_IN)
        ALU_DONE_IN && step_on && idx_r == 4'hf && !dir_r);
    c_dec_wrap: cover property (@(posedge CLK_SYS_IN)
        ALU_DONE_IN && wrap_r == APC_WRAP_4 && dir_r && idx_r[1:0] == 2'h0);
    c_rsvd_code: cover property (@(posedge CLK_SYS_IN)
        ALU_DONE_IN && wrap_r > 3'h4);
    c_load_override: cover property (@(posedge CLK_SYS_IN)
        wr_idx && ALU_DONE_IN && step_on);
endmodule
`default_nettype wire

// ### rtl/apc_pkg.sv
package apc_pkg;
    localparam int          APC_DATA_W      = 8;
    localparam int          APC_IDX_W       = 4;
    localparam int          APC_WRAP_W      = 3;
    localparam int          APC_ADDR_W      = 4;
    // module/index address of the control register and the index register
    localparam logic [3:0]  APC_CTRL_IDX    = 4'h1;
    localparam logic [3:0]  APC_INDEX_IDX   = 4'h0;
    localparam int          APC_ZERO_BIT    = 7;
    localparam int          APC_DIR_BIT     = 6;
    localparam int          APC_WRAP_LSB    = 0;
    localparam logic [7:0]  APC_CTRL_RST    = 8'h00;
    localparam logic [3:0]  APC_INDEX_RST   = 4'h0;
    localparam logic [7:0]  APC_CTRL_RDMASK = 8'h47;
    localparam logic [2:0]  APC_WRAP_OFF    = 3'h0;
    localparam logic [2:0]  APC_WRAP_2      = 3'h1;
    localparam logic [2:0]  APC_WRAP_4      = 3'h2;
    localparam logic [2:0]  APC_WRAP_8      = 3'h3;
    localparam logic [3:0]  APC_MASK_2      = 4'h1;
    localparam logic [3:0]  APC_MASK_4      = 4'h3;
    localparam logic [3:0]  APC_MASK_8      = 4'h7;
    localparam logic [3:0]  APC_MASK_16     = 4'hf;
    localparam logic [3:0]  APC_ONE         = 4'h1;
    typedef enum logic [1:0] {
        APC_ACT_HOLD,
        APC_ACT_ZERO,
        APC_ACT_STEP,
        APC_ACT_LOAD
    } apc_act_type;
endpackage

// ### rtl/apc_step.sv
`timescale 1ns/1ps
`default_nettype none
// computes the stepped index for a wrap size and direction
module apc_step
    import apc_pkg::*;
(
    input  wire logic [APC_IDX_W-1:0]  idx_in,
    input  wire logic [APC_WRAP_W-1:0] wrap_in,
    input  wire logic                  dir_in,
    output logic      [APC_IDX_W-1:0]  idx_out,
    output logic                       active_out
);
    function automatic logic [APC_IDX_W-1:0] wrap_mask(
        input logic [APC_WRAP_W-1:0] w
    );
        case (w)
            APC_WRAP_OFF: wrap_mask = '0;
            APC_WRAP_2:   wrap_mask = APC_MASK_2;
            APC_WRAP_4:   wrap_mask = APC_MASK_4;
            APC_WRAP_8:   wrap_mask = APC_MASK_8;
            default:      wrap_mask = APC_MASK_16;
        endcase
    endfunction

    logic [APC_IDX_W-1:0] mask;
    logic [APC_IDX_W-1:0] moved;

    always_comb
    begin
        mask       = wrap_mask(wrap_in);
        moved      = dir_in ? idx_in - APC_ONE : idx_in + APC_ONE;
        // low bits step modulo 2^n, upper bits kept
        idx_out    = (moved & mask) | (idx_in & ~mask);
        active_out = (wrap_in != APC_WRAP_OFF);
    end
endmodule
`default_nettype wire

// ### rtl/apc_regs.sv
`timescale 1ns/1ps
`default_nettype none
// read multiplexer for the two pointer registers
module apc_regs
    import apc_pkg::*;
(
    input  wire logic [APC_ADDR_W-1:0] addr_in,
    input  wire logic [APC_DATA_W-1:0] ctrl_in,
    input  wire logic [APC_IDX_W-1:0]  idx_in,
    output logic      [APC_DATA_W-1:0] data_out
);
    always_comb
    begin
        if (addr_in == APC_CTRL_IDX)
            data_out = ctrl_in & APC_CTRL_RDMASK;
        else if (addr_in == APC_INDEX_IDX)
            data_out = {{(APC_DATA_W-APC_IDX_W){1'b0}}, idx_in};
        else
            data_out = '0;
    end
endmodule
`default_nettype wire

// ### verif/apc_alu_model.sv
`timescale 1ns/1ps
`default_nettype none
// stands in for the core's execution unit
module apc_alu_model
(
    input  wire logic clk_in,
    output logic      done_out
);
    initial done_out = 1'b0;
    // n operations, gap idle cycles after each (0 = back to back)
    task automatic issue(input int n, input int gap);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_in);
            done_out <= 1'b1;
            repeat (gap)
            begin
                @(posedge clk_in);
                done_out <= 1'b0;
            end
        end
        @(posedge clk_in);
        done_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ### verif/accumulator_pointer_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module accumulator_pointer_control_tb;
    import apc_pkg::*;
    logic                  clk;
    logic                  nrst;
    logic                  wr;
    logic                  done;
    logic [APC_ADDR_W-1:0] addr;
    logic [APC_DATA_W-1:0] wdata;
    logic [APC_DATA_W-1:0] rdata;
    logic [APC_DATA_W-1:0] rd;
    logic [APC_IDX_W-1:0]  idx;
    logic [APC_IDX_W-1:0]  exp_idx;
    int                    num_errors = 0;
    int                    comparisons = 0;
    apc_top uut (.CLK_SYS_IN(clk), .NRST_IN(nrst), .REG_WR_IN(wr),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .ALU_DONE_IN(done),
        .REG_RDATA_OUT(rdata), .ACC_INDEX_OUT(idx));
    apc_alu_model alu (.clk_in(clk), .done_out(done));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 rd = rdata;
    endtask
    function automatic logic [3:0] nxt(input logic [3:0] i,
                                       input logic [2:0] w, input logic d);
        logic [3:0] m;
        m = (w == 3'h0) ? 4'h0 : (w == 3'h1) ? 4'h1 :
            (w == 3'h2) ? 4'h3 : (w == 3'h3) ? 4'h7 : 4'hf;
        return (i & ~m) | ((d ? i - 4'h1 : i + 4'h1) & m);
    endfunction
    task automatic t_reset;
        reg_rd(4'h1);
        check("ctrl after reset", rd, 8'h00);
        check("index after reset", {4'h0, idx}, 8'h00);
        reg_rd(4'h2);
        check("unmapped read", rd, 8'h00);
        reg_wr(4'h0, 8'h0a);
        reg_wr(4'h1, 8'h45);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        reg_rd(4'h1);
        check("ctrl after second reset", rd, 8'h00);
        check("index after second reset", {4'h0, idx}, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_modes;
        for (int w = 0; w < 8; w++)
            for (int d = 0; d < 2; d++)
            begin
                reg_wr(4'h1, {1'b1, d[0], 3'h7, w[2:0]});
                check("index after clear", {4'h0, idx}, 8'h00);
                reg_rd(4'h1);
                check("ctrl readback", rd, {1'b0, d[0], 3'h0, w[2:0]});
                reg_wr(4'h0, 8'hfb);
                check("index load", {4'h0, idx}, 8'h0b);
                reg_rd(4'h0);
                check("index read", rd, 8'h0b);
                exp_idx = 4'hb;
                repeat (5) exp_idx = nxt(exp_idx, w[2:0], d[0]);
                alu.issue(5, w % 3);
                #1;
                check("stepped index", {4'h0, idx}, {4'h0, exp_idx});
            end
        $display("t_modes done");
    endtask
    task automatic t_prio;
        reg_wr(4'h1, 8'h02);
        reg_wr(4'h0, 8'h05);
        fork
            alu.issue(1, 0);
            reg_wr(4'h1, 8'hc2);
        join
        check("clear beats step", {4'h0, idx}, 8'h00);
        alu.issue(1, 0);
        #1;
        check("step after clear", {4'h0, idx}, 8'h03);
        reg_wr(4'h1, 8'h03);
        reg_wr(4'h0, 8'h02);
        fork
            alu.issue(1, 0);
            reg_wr(4'h0, 8'h09);
        join
        check("step beats load", {4'h0, idx}, 8'h03);
        $display("t_prio done");
    endtask
    initial
    begin
        #200000;
        num_errors++;
        end_sim();
    end
    initial
    begin
        nrst = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_modes();
        t_prio();
        end_sim();
    end
endmodule
`default_nettype wire
